// [src/bpu_pkg.sv]
// Package with the constants and carrier types of the branch prediction unit.
package bpu_pkg;
   localparam int ADDR_W       = 32;
   localparam int HIST_ENTRIES = 8192;
   localparam int HIST_IDX_W   = 13;
   localparam int GHR_W        = 8;
   localparam int TC_ENTRIES   = 16;
   localparam int TC_BYTES     = 16;
   localparam int RAS_ENTRIES  = 16;
   localparam int MAX_UNRES    = 7;
   localparam int TAG_W        = 3;
   localparam int CAND_N       = 4;
   localparam logic [1:0] CTR_RESET = 2'h1;
   localparam logic [3:0] FETCH_STEP = 4'h4;

   typedef enum logic [1:0] {BR_NONE, BR_COND, BR_UNCOND, BR_CALL} br_kind_base_t;

   // One decoded instruction slot offered by the decoder.
   typedef struct packed {
      logic                          valid;
      logic                          is_cond;
      logic                          is_uncond;
      logic                          is_call;
      logic                          is_ret;
      logic [ADDR_W-1:0]             pc;
      logic [ADDR_W-1:0]             next_pc;
      logic [CAND_N-1:0]             cand_ok;
      logic [CAND_N-1:0][ADDR_W-1:0] cand_disp;
   } dec_slot_t;

   // Result of the branch condition unit.
   typedef struct packed {
      logic              valid;
      logic [TAG_W-1:0]  tag;
      logic              taken;
      logic [ADDR_W-1:0] target;
   } resolve_t;

   // Redirect sent to fetch.
   typedef struct packed {
      logic              valid;
      logic [ADDR_W-1:0] pc;
      logic              tc_hit;
      logic [TC_BYTES*8-1:0] tc_bytes;
   } redirect_t;
endpackage

// [src/branch_prediction_unit.sv]
// Branch prediction, target cache, return stack and branch resolution.
//
// How it works
// - two-level adaptive predictor: global history xor pc indexes an 8192-entry counter table.
// - no targets stored; parallel adders form candidates, first valid one is chosen.
// - unconditional branches redirect fetch in the decode cycle, no bubble.
// - target cache holds 16 entries of 16 instruction bytes each.
// - taken prediction hitting target cache sends its 16 bytes to instruction buffer.
// - return stack of 16 entries caches return addresses.
// - call pushes following address; return pops it and fetches from it.
// - not-taken conditional branch causes no redirect.
// - commit allowed only while no unresolved branch is tracked; a misprediction clears all tracking.
// - misprediction flushes younger work, restores checkpoint, fetches correct path.
// - at most seven unresolved branches; decode stalls at the limit.
// - condition unit resolves one branch per clock with one cycle latency.
`timescale 1ns/1ps
`default_nettype none
module branch_prediction_unit
#(
   parameter int HIST_ENTRIES = bpu_pkg::HIST_ENTRIES,
   parameter int TC_ENTRIES   = bpu_pkg::TC_ENTRIES,
   parameter int RAS_ENTRIES  = bpu_pkg::RAS_ENTRIES
)
(
   input  wire logic                         i_clk,
   input  wire logic                         i_rst_n,
   input  wire bpu_pkg::dec_slot_t           i_dec,
   input  wire bpu_pkg::resolve_t            i_res,
   input  wire logic                         i_res_is_ret,
   input  wire logic                         i_tc_fill,
   input  wire logic [bpu_pkg::ADDR_W-1:0]   i_tc_fill_pc,
   input  wire logic [bpu_pkg::TC_BYTES*8-1:0] i_tc_fill_bytes,
   input  wire logic                         i_commit_req,
   output var  bpu_pkg::redirect_t           o_redirect,
   output logic                              o_pred_taken,
   output logic [bpu_pkg::TAG_W-1:0]         o_br_tag,
   output logic                              o_stall,
   output logic                              o_flush,
   output logic [bpu_pkg::TAG_W-1:0]         o_flush_tag,
   output logic                              o_commit_ok
);
   localparam int HW = $clog2(HIST_ENTRIES);
   localparam int TW = $clog2(TC_ENTRIES);
   localparam int RW = $clog2(RAS_ENTRIES);
   localparam int AW = bpu_pkg::ADDR_W;
   localparam int G  = bpu_pkg::GHR_W;

   initial
   begin
      if (HIST_ENTRIES < 2 || (1 << HW) != HIST_ENTRIES || HW < G)
         $error("HIST_ENTRIES must be a power of two of at least 2**GHR_W");
      if ((1 << TW) != TC_ENTRIES || (1 << RW) != RAS_ENTRIES || TW + 4 > AW)
         $error("table sizes must be powers of two");
   end

   function automatic logic [HW-1:0] hist_index(input logic [AW-1:0] pc, input logic [G-1:0] ghr);
      hist_index = pc[HW+1:2] ^ {{(HW-G){1'b0}}, ghr};
   endfunction

   function automatic logic [TW-1:0] tc_index(input logic [AW-1:0] pc);
      tc_index = pc[TW+3:4];
   endfunction

   // Storage.
   logic [1:0]              hist_reg [HIST_ENTRIES];
   logic [G-1:0]            ghr_reg;
   logic [AW-1:0]           tc_tag_reg [TC_ENTRIES];
   logic [TC_ENTRIES-1:0]   tc_val_reg;
   logic [bpu_pkg::TC_BYTES*8-1:0] tc_data_reg [TC_ENTRIES];
   logic [AW-1:0]           ras_reg [RAS_ENTRIES];
   logic [RW-1:0]           ras_top_reg;
   logic [RW:0]             ras_cnt_reg;
   // Per-branch checkpoints so a flush can put history and stack back as they were.
   logic [bpu_pkg::MAX_UNRES:0]   pend_reg;
   logic [G-1:0]            ck_ghr_reg [8];
   logic [RW-1:0]           ck_top_reg [8];
   logic [RW:0]             ck_cnt_reg [8];
   logic [HW-1:0]           ck_idx_reg [8];
   logic                    ck_pred_reg [8];
   logic [AW-1:0]           ck_tgt_reg [8];
   logic [AW-1:0]           ck_fall_reg [8];
   logic [2:0]              unres_cnt_reg;
   logic [bpu_pkg::TAG_W-1:0] alloc_tag_reg;
   bpu_pkg::resolve_t       res_reg;
   logic                    res_ret_reg;

   // Candidate target choice: first adder whose result the decoder marks valid.
   logic [AW-1:0] cand_tgt;
   always_comb
   begin
      cand_tgt = i_dec.next_pc;
      for (int k = bpu_pkg::CAND_N-1; k >= 0; k--)
         if (i_dec.cand_ok[k])
            cand_tgt = i_dec.pc + i_dec.cand_disp[k];
   end

   wire [HW-1:0] h_idx    = hist_index(i_dec.pc, ghr_reg);
   wire          pred_tk  = hist_reg[h_idx][1];
   wire          at_limit = (unres_cnt_reg == 3'(bpu_pkg::MAX_UNRES));
   wire          is_br    = i_dec.is_cond | i_dec.is_ret;
   wire          dec_go   = i_dec.valid & ~(is_br & at_limit) & ~o_flush;
   wire          ras_empty = (ras_cnt_reg == '0);
   wire [AW-1:0] ras_pop  = ras_reg[ras_top_reg];
   wire          take     = dec_go & (i_dec.is_uncond | i_dec.is_call | i_dec.is_ret
                                      | (i_dec.is_cond & pred_tk));
   wire [AW-1:0] tgt      = i_dec.is_ret ? (ras_empty ? i_dec.next_pc : ras_pop) : cand_tgt;
   wire [TW-1:0] t_idx    = tc_index(tgt);
   wire          tc_hit   = tc_val_reg[t_idx] & (tc_tag_reg[t_idx] == tgt);
   wire          alloc    = dec_go & is_br;

   // Resolution stage: compare registered outcome against checkpointed prediction.
   wire [2:0]    rt       = res_reg.tag;
   wire          act_tgt_eq = (res_reg.target == ck_tgt_reg[rt]);
   wire          mispred  = res_reg.valid & pend_reg[rt] &
                            ((res_reg.taken != ck_pred_reg[rt]) | (res_reg.taken & ~act_tgt_eq));
   wire          res_ok   = res_reg.valid & pend_reg[rt];

   // Condition unit input register gives one-cycle latency at one per clock.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         res_reg     <= '0;
         res_ret_reg <= 1'b0;
      end
      else
      begin
         res_reg     <= i_res;
         res_ret_reg <= i_res_is_ret;
      end
   end

   // Prediction outputs and redirect to fetch, registered.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         o_redirect   <= '0;
         o_pred_taken <= 1'b0;
         o_br_tag     <= '0;
         o_flush      <= 1'b0;
         o_flush_tag  <= '0;
      end
      else if (mispred)
      begin
         o_redirect.valid <= 1'b1;
         o_redirect.pc    <= res_reg.taken ? res_reg.target : ck_fall_reg[rt];
         o_redirect.tc_hit <= 1'b0;
         o_flush      <= 1'b1;
         o_flush_tag  <= rt;
         o_pred_taken <= 1'b0;
      end
      else
      begin
         o_flush          <= 1'b0;
         o_redirect.valid <= take;
         o_redirect.pc    <= tgt;
         o_redirect.tc_hit <= take & tc_hit;
         o_redirect.tc_bytes <= tc_data_reg[t_idx];
         o_pred_taken <= take;
         o_br_tag     <= alloc_tag_reg;
      end
   end

   // Global history; flush restores the checkpointed history, with the resolved outcome shifted in except for a return.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         ghr_reg <= '0;
      else if (mispred)
         // A return never shifted history when predicted, so its checkpoint is put back as it was.
         ghr_reg <= res_ret_reg ? ck_ghr_reg[rt] : {ck_ghr_reg[rt][G-2:0], res_reg.taken};
      else if (dec_go & i_dec.is_cond)
         ghr_reg <= {ghr_reg[G-2:0], pred_tk};
   end

   // Counters are trained at resolution with the index captured at prediction.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         for (int k = 0; k < HIST_ENTRIES; k++)
            hist_reg[k] <= bpu_pkg::CTR_RESET;
      else if (res_ok & ~res_ret_reg)
      begin
         if (res_reg.taken && hist_reg[ck_idx_reg[rt]] != 2'h3)
            hist_reg[ck_idx_reg[rt]] <= hist_reg[ck_idx_reg[rt]] + 2'h1;
         else if (!res_reg.taken && hist_reg[ck_idx_reg[rt]] != 2'h0)
            hist_reg[ck_idx_reg[rt]] <= hist_reg[ck_idx_reg[rt]] - 2'h1;
      end
   end

   // Target cache, direct mapped, filled by fetch after a redirect miss.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         tc_val_reg <= '0;
      else if (i_tc_fill)
      begin
         tc_val_reg[tc_index(i_tc_fill_pc)]  <= 1'b1;
         tc_tag_reg[tc_index(i_tc_fill_pc)]  <= i_tc_fill_pc;
         tc_data_reg[tc_index(i_tc_fill_pc)] <= i_tc_fill_bytes;
      end
   end

   // Return stack: circular, so a push onto a full stack overwrites the oldest entry.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         ras_top_reg <= '0;
         ras_cnt_reg <= '0;
      end
      else if (mispred)
      begin
         // A mispredicted return still consumed its entry, so the pop is redone on the checkpoint.
         if (res_ret_reg && ck_cnt_reg[rt] != '0)
         begin
            ras_top_reg <= ck_top_reg[rt] - RW'(1);
            ras_cnt_reg <= ck_cnt_reg[rt] - (RW+1)'(1);
         end
         else
         begin
            ras_top_reg <= ck_top_reg[rt];
            ras_cnt_reg <= ck_cnt_reg[rt];
         end
      end
      else if (dec_go & i_dec.is_call)
      begin
         ras_top_reg <= ras_top_reg + RW'(1);
         ras_reg[ras_top_reg + RW'(1)] <= i_dec.next_pc;
         if (ras_cnt_reg != (RW+1)'(RAS_ENTRIES))
            ras_cnt_reg <= ras_cnt_reg + (RW+1)'(1);
      end
      else if (dec_go & i_dec.is_ret & ~ras_empty)
      begin
         ras_top_reg <= ras_top_reg - RW'(1);
         ras_cnt_reg <= ras_cnt_reg - (RW+1)'(1);
      end
   end

   // Branch tracking: allocate a checkpoint per conditional branch or return, free on resolution.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         pend_reg      <= '0;
         unres_cnt_reg <= '0;
         alloc_tag_reg <= '0;
      end
      else if (mispred)
      begin
         pend_reg      <= '0;
         unres_cnt_reg <= '0;
      end
      else
      begin
         if (alloc)
         begin
            pend_reg[alloc_tag_reg]    <= 1'b1;
            ck_ghr_reg[alloc_tag_reg]  <= ghr_reg;
            ck_top_reg[alloc_tag_reg]  <= ras_top_reg;
            ck_cnt_reg[alloc_tag_reg]  <= ras_cnt_reg;
            ck_idx_reg[alloc_tag_reg]  <= h_idx;
            ck_pred_reg[alloc_tag_reg] <= i_dec.is_ret ? 1'b1 : pred_tk;
            ck_tgt_reg[alloc_tag_reg]  <= i_dec.is_ret & ras_empty ? ~tgt : tgt;
            ck_fall_reg[alloc_tag_reg] <= i_dec.next_pc;
            alloc_tag_reg <= alloc_tag_reg + 3'h1;
         end
         if (res_ok)
            pend_reg[rt] <= 1'b0;
         unres_cnt_reg <= unres_cnt_reg + 3'(alloc) - 3'(res_ok);
      end
   end

   // Stall and commit gates; commit waits until no branch is tracked, and a misprediction clears all tracking.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         o_stall     <= 1'b0;
         o_commit_ok <= 1'b0;
      end
      else
      begin
         o_stall     <= (unres_cnt_reg + 3'(alloc) - 3'(res_ok)) == 3'(bpu_pkg::MAX_UNRES);
         o_commit_ok <= i_commit_req & ~mispred & (unres_cnt_reg + 3'(alloc) - 3'(res_ok)) == 3'h0;
      end
   end

   property p_stall_limit;
      @(posedge i_clk) disable iff (!i_rst_n) (unres_cnt_reg == 3'h7) |-> !alloc;
   endproperty
   a_stall_limit: assert property (p_stall_limit) else $error("branch allocated past limit");

   property p_commit_safe;
      @(posedge i_clk) disable iff (!i_rst_n) o_commit_ok |-> unres_cnt_reg == 3'h0;
   endproperty
   a_commit_safe: assert property (p_commit_safe) else $error("commit with unresolved branch");

   property p_uncond;
      @(posedge i_clk) disable iff (!i_rst_n)
         (i_dec.valid & i_dec.is_uncond & !o_flush & !mispred) |=> (o_redirect.valid && o_redirect.pc == $past(cand_tgt));
   endproperty
   a_uncond: assert property (p_uncond) else $error("unconditional branch not redirected");

   property p_flush;
      @(posedge i_clk) disable iff (!i_rst_n) mispred |=> (o_flush && o_redirect.valid && pend_reg == '0);
   endproperty
   a_flush: assert property (p_flush) else $error("misprediction not recovered");

   property p_not_taken;
      @(posedge i_clk) disable iff (!i_rst_n)
         (i_dec.valid & i_dec.is_cond & !pred_tk & !mispred & !i_dec.is_uncond & !i_dec.is_call & !i_dec.is_ret)
         |=> !o_redirect.valid;
   endproperty
   a_not_taken: assert property (p_not_taken) else $error("not-taken branch redirected");

   property p_call_push;
      @(posedge i_clk) disable iff (!i_rst_n)
         (dec_go & i_dec.is_call & !mispred) |=> ras_reg[ras_top_reg] == $past(i_dec.next_pc);
   endproperty
   a_call_push: assert property (p_call_push) else $error("call did not push return address");

   property p_res_latency;
      @(posedge i_clk) disable iff (!i_rst_n) i_res.valid |=> (res_reg.valid && res_reg.tag == $past(i_res.tag));
   endproperty
   a_res_latency: assert property (p_res_latency) else $error("resolution latency broken");

   property p_tc_hit;
      @(posedge i_clk) disable iff (!i_rst_n) o_redirect.tc_hit |-> (o_redirect.valid && !o_flush);
   endproperty
   a_tc_hit: assert property (p_tc_hit) else $error("target bytes sent without taken redirect");
endmodule
`default_nettype wire

// [tb/fe_model.sv]
// Behavioural model of the fetch, decode and scheduler logic beside the branch unit.
`timescale 1ns/1ps
`default_nettype none
module fe_model
(
   input  wire logic                         i_clk,
   input  wire logic                         i_stall,
   input  wire logic                         i_flush,
   output var  bpu_pkg::dec_slot_t           o_dec,
   output var  bpu_pkg::resolve_t            o_res,
   output logic                              o_res_is_ret,
   output logic                              o_tc_fill,
   output logic [bpu_pkg::ADDR_W-1:0]        o_tc_fill_pc,
   output logic [bpu_pkg::TC_BYTES*8-1:0]    o_tc_fill_bytes,
   output logic                              o_commit_req
);
   // Everything starts idle so the unit sees no request during reset.
   initial
   begin
      o_dec = '0;
      o_res = '0;
      o_res_is_ret = 1'b0;
      o_tc_fill = 1'b0;
      o_tc_fill_pc = '0;
      o_tc_fill_bytes = '0;
      o_commit_req = 1'b0;
   end

   // Offers one slot; released lines toggle so stale values are never mistaken for a request.
   task automatic decode(input logic [3:0] kind, input logic [31:0] pc, input logic [31:0] disp);
      int n;
      n = 0;
      @(negedge i_clk);
      while ((i_flush || (i_stall && (kind[3] || kind[0]))) && n < 20)
      begin
         n++;
         @(negedge i_clk);
      end
      {o_dec.is_cond, o_dec.is_uncond, o_dec.is_call, o_dec.is_ret} = kind;
      o_dec.pc = pc;
      o_dec.next_pc = pc + 32'h4;
      o_dec.cand_ok = 4'h6;
      for (int i = 0; i < 4; i++)
         o_dec.cand_disp[i] = disp + i * 32'h100;
      o_dec.valid = 1'b1;
      @(negedge i_clk);
      o_dec.valid = 1'b0;
      {o_dec.pc, o_dec.next_pc, o_dec.cand_disp} = ~{o_dec.pc, o_dec.next_pc, o_dec.cand_disp};
   endtask

   // Presents one result; several calls in a row give one result per clock.
   task automatic resolve(input logic [bpu_pkg::TAG_W-1:0] tag, input logic taken, input logic [31:0] tgt,
                          input logic is_ret);
      @(negedge i_clk);
      o_res.valid = 1'b1;
      o_res.tag = tag;
      o_res.taken = taken;
      o_res.target = tgt;
      o_res_is_ret = is_ret;
   endtask

   // Ends a run of results.
   task automatic res_idle();
      @(negedge i_clk);
      o_res.valid = 1'b0;
      {o_res.tag, o_res.taken, o_res.target} = ~{o_res.tag, o_res.taken, o_res.target};
   endtask

   // Writes one line of target bytes into the cache.
   task automatic fill(input logic [31:0] pc, input logic [127:0] bytes);
      @(negedge i_clk);
      o_tc_fill_pc = pc;
      o_tc_fill_bytes = bytes;
      o_tc_fill = 1'b1;
      @(negedge i_clk);
      o_tc_fill = 1'b0;
      o_tc_fill_bytes = ~o_tc_fill_bytes;
   endtask
endmodule
`default_nettype wire

// [tb/branch_prediction_unit_tb_top.sv]
// Self-checking testbench for the branch prediction unit.
`timescale 1ns/1ps
`default_nettype none
module branch_prediction_unit_tb_top;
   localparam logic [3:0] K_COND = 4'h8;
   localparam logic [3:0] K_JMP  = 4'h4;
   localparam logic [3:0] K_CALL = 4'h2;
   localparam logic [3:0] K_RET  = 4'h1;
   logic                 clk;
   logic                 rst_n;
   bpu_pkg::dec_slot_t   dec;
   bpu_pkg::resolve_t    res;
   bpu_pkg::redirect_t   redir;
   logic                 res_ret;
   logic                 fill;
   logic [31:0]          fill_pc;
   logic [127:0]         fill_bytes;
   logic                 commit;
   logic                 pred_taken;
   logic [2:0]           br_tag;
   logic                 stall;
   logic                 flush;
   logic [2:0]           flush_tag;
   logic                 commit_ok;
   int                   failures;
   int                   cmp_count;

   branch_prediction_unit u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_dec(dec), .i_res(res), .i_res_is_ret(res_ret),
      .i_tc_fill(fill), .i_tc_fill_pc(fill_pc), .i_tc_fill_bytes(fill_bytes), .i_commit_req(commit),
      .o_redirect(redir), .o_pred_taken(pred_taken), .o_br_tag(br_tag), .o_stall(stall), .o_flush(flush),
      .o_flush_tag(flush_tag), .o_commit_ok(commit_ok));

   fe_model u_fe (.i_clk(clk), .i_stall(stall), .i_flush(flush), .o_dec(dec), .o_res(res), .o_res_is_ret(res_ret),
      .o_tc_fill(fill), .o_tc_fill_pc(fill_pc), .o_tc_fill_bytes(fill_bytes), .o_commit_req(commit));

   // A 20 ns clock.
   always #10 clk = ~clk;

   // Shared compare; values are widened so one task serves every width.
   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Called just after a wrong result is taken; the flush must land exactly one cycle later.
   task automatic expect_flush(input logic [2:0] t, input logic [31:0] pc);
      chk(flush, 1'b0);
      @(negedge clk);
      chk(flush, 1'b1);
      chk(flush_tag, t);
      chk(redir.valid, 1'b1);
      chk(redir.pc, pc);
      @(negedge clk);
      chk(flush, 1'b0);
   endtask

   // A return straight after reset finds the stack empty and must be corrected.
   task automatic t_ret_empty();
      logic [2:0] t;
      u_fe.decode(K_RET, 32'h7000, 32'h0);
      t = br_tag;
      chk(redir.pc, 32'h7004);
      u_fe.resolve(t, 1'b1, 32'h7abc, 1'b1);
      u_fe.res_idle();
      expect_flush(t, 32'h7abc);
      $display("test empty return done");
   endtask

   // Jump with no cache line behind its target.
   task automatic t_jump();
      u_fe.decode(K_JMP, 32'h1000, 32'h40);
      chk(redir.valid, 1'b1);
      chk(pred_taken, 1'b1);
      chk(redir.pc, 32'h1140);
      chk(redir.tc_hit, 1'b0);
      $display("test jump done");
   endtask

   // All sixteen lines are filled, then each is hit with its own bytes.
   task automatic t_cache();
      for (int i = 0; i < 16; i++)
         u_fe.fill(32'h3140 + i * 32'h10, {16{8'(i) ^ 8'ha5}});
      for (int i = 0; i < 16; i++)
      begin
         u_fe.decode(K_JMP, 32'h3000 + i * 32'h10, 32'h40);
         chk(redir.tc_hit, 1'b1);
         chk(redir.tc_bytes, {16{8'(i) ^ 8'ha5}});
      end
      $display("test target cache done");
   endtask

   // Seventeen calls overflow the stack; sixteen returns come back newest first.
   task automatic t_ras();
      logic [2:0] t;
      for (int i = 0; i < 17; i++)
         u_fe.decode(K_CALL, 32'h5000 + i * 32'h10, 32'h40);
      for (int i = 16; i > 0; i--)
      begin
         u_fe.decode(K_RET, 32'h6000, 32'h0);
         t = br_tag;
         chk(redir.pc, 32'h5004 + i * 32'h10);
         u_fe.resolve(t, 1'b1, 32'h5004 + i * 32'h10, 1'b1);
         u_fe.res_idle();
      end
      $display("test return stack done");
   endtask

   // Seven not-taken branches fill the unit; the last is resolved wrong.
   task automatic t_cond();
      logic [2:0] tags [7];
      u_fe.o_commit_req = 1'b1;
      @(negedge clk);
      @(negedge clk);
      chk(commit_ok, 1'b1);
      for (int i = 0; i < 7; i++)
      begin
         u_fe.decode(K_COND, 32'h8000 + i * 32'h20, 32'h40);
         tags[i] = br_tag;
         chk(redir.valid, 1'b0);
         chk(pred_taken, 1'b0);
      end
      chk(stall, 1'b1);
      chk(commit_ok, 1'b0);
      for (int i = 0; i < 6; i++)
         u_fe.resolve(tags[i], 1'b0, 32'h8004 + i * 32'h20, 1'b0);
      u_fe.res_idle();
      @(negedge clk);
      chk(flush, 1'b0);
      chk(stall, 1'b0);
      chk(commit_ok, 1'b0);
      u_fe.resolve(tags[6], 1'b1, 32'h9000, 1'b0);
      u_fe.res_idle();
      expect_flush(tags[6], 32'h9000);
      repeat (3) @(negedge clk);
      chk(commit_ok, 1'b1);
      u_fe.o_commit_req = 1'b0;
      $display("test conditional done");
   endtask

   // Main sequence.
   initial
   begin
      clk = 1'b0;
      rst_n = 1'b0;
      failures = 0;
      cmp_count = 0;
      repeat (6) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      t_ret_empty();
      t_jump();
      t_cache();
      t_ras();
      t_cond();
      report_and_stop();
   end

   // The tests need well under 1000 cycles, so 50 us means a hang.
   initial
   begin
      #50us;
      failures++;
      report_and_stop();
   end
endmodule
`default_nettype wire
